/* pmdb_pkg.sv */
// Package with register map, field positions and reset values of the bank.
package pmdb_pkg;

   // Byte addresses of the two disable registers on the APB bus.
   localparam logic [11:0] PMDB_ADDR_THREE = 12'h000;
   localparam logic [11:0] PMDB_ADDR_FOUR  = 12'h004;

   // Field positions inside the 16-bit registers.
   localparam int PMDB_BIT_COMPARATOR = 10;
   localparam int PMDB_BIT_CRC        = 7;
   localparam int PMDB_BIT_SECOND_I2C = 1;
   localparam int PMDB_BIT_REF_CLOCK  = 3;
   localparam int PMDB_BIT_CHARGE     = 2;

   // Masks of implemented bits; all other positions read as zero.
   localparam logic [15:0] PMDB_MASK_THREE = 16'h0482;
   localparam logic [15:0] PMDB_MASK_FOUR  = 16'h000C;

   // Reset values: every peripheral starts enabled.
   localparam logic [15:0] PMDB_RESET_THREE = 16'h0000;
   localparam logic [15:0] PMDB_RESET_FOUR  = 16'h0000;

endpackage : pmdb_pkg

/* pmdb_reg.sv */
// One masked 16-bit disable register with byte-lane writes.
`timescale 1ns/1ps
module pmdb_reg #(
   parameter logic [15:0] MASK      = 16'h0000, // Implemented bits.
   parameter logic [15:0] RESET_VAL = 16'h0000  // Value after reset.
) (
   input  wire logic        clk,   // System clock.
   input  wire logic        rst,   // Asynchronous reset, active high.
   input  wire logic        wr,    // Write strobe for this register.
   input  wire logic [1:0]  strb,  // Byte lanes of the write.
   input  wire logic [15:0] wdata, // Write data.
   output logic      [15:0] value  // Stored, masked value.
);

   logic [15:0] next_value;

   // Only masked bits can change, so unimplemented ones stay zero.
   always_comb begin
      next_value = value;
      if (wr) begin
         if (strb[0]) begin
            next_value[7:0] = wdata[7:0] & MASK[7:0];
         end
         if (strb[1]) begin
            next_value[15:8] = wdata[15:8] & MASK[15:8];
         end
      end
   end

   // Register the next value.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         value <= RESET_VAL;
      end else begin
         value <= next_value;
      end
   end

endmodule : pmdb_reg

/* pmdb_bank.sv */
// APB register bank holding the peripheral module disable bits.
`timescale 1ns/1ps
//
// How it works
// [RULE1] Bit 10 of register three set to one disables the comparator.
// [RULE2] Bit 7 of register three set to one disables the CRC unit.
// [RULE3] Bit 1 of register three set to one disables the second I2C unit.
// [RULE4] Bit 3 of register four set to one disables the reference clock.
// [RULE5] Bit 2 of register four set to one disables charge-time measuring.
// [RULE6] All unimplemented bit positions of both registers read as zero.
// [RULE7] Reset clears every disable bit and writes to unused bits are lost.
//
module pmdb_bank (
   input  wire logic        SYS_CLK,                 // System clock.
   input  wire logic        RST,                     // Async reset, high.
   input  wire logic        PSEL,                    // APB select.
   input  wire logic        PENABLE,                 // APB access phase.
   input  wire logic        PWRITE,                  // APB direction.
   input  wire logic [11:0] PADDR,                   // APB byte address.
   input  wire logic [31:0] PWDATA,                  // APB write data.
   input  wire logic [3:0]  PSTRB,                   // APB byte strobes.
   output logic      [31:0] PRDATA,                  // APB read data.
   output logic             PREADY,                  // APB ready.
   output logic             PSLVERR,                 // APB error.
   output logic             COMPARATOR_OFF,          // Comparator disable.
   output logic             CRC_UNIT_OFF,            // CRC disable.
   output logic             SECOND_I2C_OFF,          // Second I2C disable.
   output logic             REF_CLOCK_OUT_OFF,       // Ref clock disable.
   output logic             CHARGE_TIME_UNIT_OFF     // Charge-time disable.
);
   import pmdb_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   logic [15:0] ctl_three;
   logic [15:0] ctl_four;
   logic        hit_three;
   logic        hit_four;
   logic        access;
   logic [31:0] next_rdata;
   logic        next_err;

   // Decode; the full byte address must match exactly, unmapped gets an error.
   assign hit_three = (PADDR == PMDB_ADDR_THREE);
   assign hit_four  = (PADDR == PMDB_ADDR_FOUR);
   assign access    = PSEL & PENABLE;

   ////////////////////////////////////////////////////////////////////////
   // Register three holds the comparator, CRC and second I2C bits.
   pmdb_reg #(
      .MASK      (PMDB_MASK_THREE),
      .RESET_VAL (PMDB_RESET_THREE) // RULE7
   ) u_three (
      .clk   (SYS_CLK),
      .rst   (RST),
      .wr    (access & PWRITE & hit_three),
      .strb  (PSTRB[1:0]),
      .wdata (PWDATA[15:0]),
      .value (ctl_three)
   );

   // Register four holds the reference clock and charge-time bits.
   pmdb_reg #(
      .MASK      (PMDB_MASK_FOUR),
      .RESET_VAL (PMDB_RESET_FOUR) // RULE7
   ) u_four (
      .clk   (SYS_CLK),
      .rst   (RST),
      .wr    (access & PWRITE & hit_four),
      .strb  (PSTRB[1:0]),
      .wdata (PWDATA[15:0]),
      .value (ctl_four)
   );

   ////////////////////////////////////////////////////////////////////////
   // Zero wait states keep the bank simple; every access ends at once.
   assign PREADY = 1'b1;

   // Read data is registered at the setup phase so it is ready in access.
   always_comb begin
      next_rdata = 32'h00000000;
      next_err   = 1'b0;
      if (PSEL & ~PENABLE) begin
         if (hit_three) begin
            next_rdata = {16'h0000, ctl_three & PMDB_MASK_THREE}; // RULE6
         end else if (hit_four) begin
            next_rdata = {16'h0000, ctl_four & PMDB_MASK_FOUR}; // RULE6
         end else begin
            next_err = 1'b1;
         end
      end else if (access) begin
         next_rdata = PRDATA;
         next_err   = PSLVERR;
      end
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         PRDATA  <= 32'h00000000;
         PSLVERR <= 1'b0;
      end else begin
         PRDATA  <= next_rdata;
         PSLVERR <= next_err;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Disable outputs come straight from the stored flip-flops.
   assign COMPARATOR_OFF       = ctl_three[PMDB_BIT_COMPARATOR]; // RULE1
   assign CRC_UNIT_OFF         = ctl_three[PMDB_BIT_CRC]; // RULE2
   assign SECOND_I2C_OFF       = ctl_three[PMDB_BIT_SECOND_I2C]; // RULE3
   assign REF_CLOCK_OUT_OFF    = ctl_four[PMDB_BIT_REF_CLOCK]; // RULE4
   assign CHARGE_TIME_UNIT_OFF = ctl_four[PMDB_BIT_CHARGE]; // RULE5

   ////////////////////////////////////////////////////////////////////////
   // Checks that tie the outputs and read data to bus writes, reads and reset.
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RST);

   a_comp_write: assert property ( // RULE1
      access && PWRITE && hit_three && PSTRB[1]
      |=> COMPARATOR_OFF == $past(PWDATA[PMDB_BIT_COMPARATOR]))
      else $error("Comparator disable does not follow write.");

   a_crc_write: assert property ( // RULE2
      access && PWRITE && hit_three && PSTRB[0]
      |=> CRC_UNIT_OFF == $past(PWDATA[PMDB_BIT_CRC]))
      else $error("CRC disable does not follow write.");

   a_i2c_write: assert property ( // RULE3
      access && PWRITE && hit_three && PSTRB[0]
      |=> SECOND_I2C_OFF == $past(PWDATA[PMDB_BIT_SECOND_I2C]))
      else $error("Second I2C disable does not follow write.");

   a_refclk_write: assert property ( // RULE4
      access && PWRITE && hit_four && PSTRB[0]
      |=> REF_CLOCK_OUT_OFF == $past(PWDATA[PMDB_BIT_REF_CLOCK]))
      else $error("Reference clock disable does not follow write.");

   a_charge_write: assert property ( // RULE5
      access && PWRITE && hit_four && PSTRB[0]
      |=> CHARGE_TIME_UNIT_OFF == $past(PWDATA[PMDB_BIT_CHARGE]))
      else $error("Charge-time disable does not follow write.");

   a_unused_zero: assert property ( // RULE6
      access && !PWRITE && !PSLVERR
      |-> (PRDATA & ~{16'h0000, PMDB_MASK_THREE | PMDB_MASK_FOUR})
          == 32'h00000000)
      else $error("Unimplemented bits read as nonzero.");

   a_read_match: assert property ( // RULE6
      PSEL && !PENABLE && !PWRITE && hit_four
      |=> PRDATA == {28'h0000000, REF_CLOCK_OUT_OFF,
                     CHARGE_TIME_UNIT_OFF, 2'b00})
      else $error("Register four read does not match outputs.");

   a_hold_value: assert property ( // RULE7
      !(access && PWRITE)
      |=> $stable(ctl_three) && $stable(ctl_four))
      else $error("Disable bits changed without a write.");

   a_reset_clear: assert property ( // RULE7
      $fell(RST) |-> ctl_three == 16'h0000 && ctl_four == 16'h0000)
      else $error("Disable bits not clear after reset.");

   a_unmapped_err: assert property (
      PSEL && !PENABLE && !hit_three && !hit_four |=> PSLVERR)
      else $error("Unmapped access gives no error.");

   ////////////////////////////////////////////////////////////////////////
   // Bus timing checks. The slave never stretches a transfer, so a master
   // that waits for ready always finishes in two cycles. Read data is
   // loaded in the setup cycle and must not move during the access cycle,
   // because the master may take it anywhere up to the closing edge.
   // Outside a transfer both data and error fall back to zero, which
   // keeps a stale read value from being mistaken for a fresh one.

   // Ready is tied high; a change here would need a new master contract.
   a_ready_high: assert property (
      PREADY == 1'b1)
      else $error("Ready is not high.");

   // An idle cycle clears the error flag for the next transfer.
   a_idle_err: assert property (
      !PSEL |=> !PSLVERR)
      else $error("Error flag stays up while idle.");

   // An idle cycle clears the read data as well.
   a_idle_rdata: assert property (
      !PSEL |=> PRDATA == 32'h00000000)
      else $error("Read data not cleared while idle.");

   // Read data and error hold steady through the access cycle.
   a_access_hold: assert property (
      access |=> $stable(PRDATA) && $stable(PSLVERR))
      else $error("Read data moved during access.");

   // Unmapped reads return zero with the error flag.
   a_unmapped_zero: assert property (
      PSEL && !PENABLE && !hit_three && !hit_four
      |=> PRDATA == 32'h00000000)
      else $error("Unmapped read returns nonzero data.");

   // Mapped addresses never raise the error flag.
   a_mapped_ok: assert property (
      PSEL && !PENABLE && (hit_three || hit_four) |=> !PSLVERR)
      else $error("Mapped access raises an error.");

   // Register three read places each bit at its own position.
   a_read_three: assert property ( // RULE6
      PSEL && !PENABLE && !PWRITE && hit_three
      |=> PRDATA == {21'h000000, COMPARATOR_OFF, 2'b00, CRC_UNIT_OFF,
                     5'b00000, SECOND_I2C_OFF, 1'b0})
      else $error("Register three read does not match outputs.");

   ////////////////////////////////////////////////////////////////////////
   // Storage checks. The masks in the register instances keep the stored
   // unimplemented bits at zero and the read path masks them again, so
   // they are watched directly rather than only through the read path.

   // Unimplemented bits of register three never hold a one.
   a_three_unused: assert property ( // RULE6
      (ctl_three & ~PMDB_MASK_THREE) == 16'h0000)
      else $error("Register three holds an unimplemented bit.");

   // Unimplemented bits of register four never hold a one.
   a_four_unused: assert property ( // RULE6
      (ctl_four & ~PMDB_MASK_FOUR) == 16'h0000)
      else $error("Register four holds an unimplemented bit.");

   // A refused write changes neither register.
   a_unmapped_keep: assert property ( // RULE7
      access && PWRITE && !hit_three && !hit_four
      |=> $stable(ctl_three) && $stable(ctl_four))
      else $error("Unmapped write changed a register.");

   // A write to register three leaves register four alone.
   a_three_only: assert property ( // RULE4
      access && PWRITE && hit_three |=> $stable(ctl_four))
      else $error("Write to register three changed register four.");

   // A write to register four leaves register three alone.
   a_four_only: assert property ( // RULE1
      access && PWRITE && hit_four |=> $stable(ctl_three))
      else $error("Write to register four changed register three.");

   // Without the upper lane the comparator bit keeps its value.
   a_lane_high: assert property ( // RULE1
      access && PWRITE && hit_three && !PSTRB[1]
      |=> $stable(COMPARATOR_OFF))
      else $error("Comparator bit changed without its lane.");

   // Without the lower lane the CRC and I2C bits keep their value.
   a_lane_low: assert property ( // RULE2
      access && PWRITE && hit_three && !PSTRB[0]
      |=> $stable(CRC_UNIT_OFF) && $stable(SECOND_I2C_OFF))
      else $error("Low bits of register three changed without lane.");

   // Without the lower lane register four keeps its bits.
   a_lane_four: assert property ( // RULE5
      access && PWRITE && hit_four && !PSTRB[0]
      |=> $stable(REF_CLOCK_OUT_OFF) && $stable(CHARGE_TIME_UNIT_OFF))
      else $error("Register four changed without its lane.");

   c_comp_off:  cover property (access && PWRITE && hit_three
                                ##1 COMPARATOR_OFF);
   c_read_four: cover property (access && !PWRITE && hit_four
                                && PRDATA != 32'h00000000);
   c_unmapped:  cover property (access && PSLVERR);
   c_ref_off:   cover property (access && PWRITE && hit_four
                                ##1 REF_CLOCK_OUT_OFF);

endmodule : pmdb_bank

/* pmdb_testbench.sv */
// Self-checking bench for the peripheral module disable register bank.
`timescale 1ns/1ps
module testbench;
   import pmdb_pkg::*;
   logic        SYS_CLK = 1'b0;
   logic        RST     = 1'b1;
   logic        PSEL    = 1'b0;
   logic        PENABLE = 1'b0;
   logic        PWRITE  = 1'b0;
   logic [11:0] PADDR   = 12'h000;
   logic [31:0] PWDATA  = 32'h0;
   logic [3:0]  PSTRB   = 4'h0;
   wire  [31:0] PRDATA;
   wire         PREADY;
   wire         PSLVERR;
   wire  [4:0]  offs;
   int          n_errors = 0;
   int          checks   = 0;
   logic [31:0] rd;
   logic        err;
   int          pos [5]  = '{PMDB_BIT_COMPARATOR, PMDB_BIT_CRC,
                             PMDB_BIT_SECOND_I2C, PMDB_BIT_REF_CLOCK,
                             PMDB_BIT_CHARGE};
   pmdb_bank pmdb_bank_inst (.SYS_CLK(SYS_CLK), .RST(RST), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
      .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .COMPARATOR_OFF(offs[4]), .CRC_UNIT_OFF(offs[3]),
      .SECOND_I2C_OFF(offs[2]), .REF_CLOCK_OUT_OFF(offs[1]),
      .CHARGE_TIME_UNIT_OFF(offs[0]));
   ////////////////////////////////////////////////////////////////////////
   // Free-running 100 MHz system clock.
   initial begin
      forever #5 SYS_CLK = ~SYS_CLK;
   end
   // One APB transfer; an idle cycle follows so no signal is set twice.
   task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d, input logic [3:0] s,
      output logic [31:0] r, output logic e);
      PSEL    <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE  <= wr;
      PADDR   <= a;
      PWDATA  <= d;
      PSTRB   <= s;
      @(posedge SYS_CLK);
      PENABLE <= 1'b1;
      @(posedge SYS_CLK);
      while (PREADY !== 1'b1) @(posedge SYS_CLK);
      r = PRDATA;
      e = PSLVERR;
      PSEL    <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge SYS_CLK);
   endtask : apb
   // Compare and count; four-state equality so unknowns never match.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   // Print the counts and the verdict, then stop.
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : wrap_up
   // Watchdog well beyond the roughly 80 cycles the tests need.
   initial begin
      #20us;
      n_errors++;
      $display("unexpected at %0t: watchdog expired", $time);
      wrap_up();
   end
   ////////////////////////////////////////////////////////////////////////
   // Main sequence of register tests.
   initial begin
      repeat (10) @(posedge SYS_CLK);
      RST <= 1'b0;
      @(posedge SYS_CLK);
      apb(1'b0, PMDB_ADDR_THREE, 32'h0, 4'h0, rd, err);
      chk(rd, 32'h0);
      apb(1'b0, PMDB_ADDR_FOUR, 32'h0, 4'h0, rd, err);
      chk(rd, 32'h0);
      chk({27'h0, offs}, 32'h0);
      $display("test reset values done");
      // Each disable bit alone drives its own output and no other.
      for (int i = 0; i < 5; i++) begin
         PADDR <= (i < 3) ? PMDB_ADDR_THREE : PMDB_ADDR_FOUR;
         @(posedge SYS_CLK);
         apb(1'b1, PADDR, 32'h1 << pos[i], 4'h3, rd, err);
         chk({27'h0, offs}, 32'h10 >> i);
         apb(1'b1, PADDR, 32'h0, 4'h3, rd, err);
      end
      $display("test single bits done");
      // All ones: unused positions stay zero; low lane first, then both.
      apb(1'b1, PMDB_ADDR_THREE, 32'hFFFFFFFF, 4'h1, rd, err);
      apb(1'b0, PMDB_ADDR_THREE, 32'h0, 4'h0, rd, err);
      chk(rd, 32'h00000082);
      apb(1'b1, PMDB_ADDR_THREE, 32'hFFFFFFFF, 4'hF, rd, err);
      apb(1'b0, PMDB_ADDR_THREE, 32'h0, 4'h0, rd, err);
      chk(rd, 32'h00000482);
      apb(1'b1, PMDB_ADDR_FOUR, 32'hFFFFFFFF, 4'hF, rd, err);
      apb(1'b0, PMDB_ADDR_FOUR, 32'h0, 4'h0, rd, err);
      chk(rd, 32'h0000000C);
      chk({27'h0, offs}, 32'h1F);
      chk({31'h0, err}, 32'h0);
      $display("test unused bits done");
      // Unmapped address is refused and leaves the bank untouched.
      apb(1'b1, 12'h008, 32'h0, 4'hF, rd, err);
      chk({31'h0, err}, 32'h1);
      apb(1'b0, 12'h008, 32'h0, 4'h0, rd, err);
      chk(rd, 32'h0);
      chk({27'h0, offs}, 32'h1F);
      $display("test unmapped address done");
      // A reset in mid-run clears every disable bit.
      RST <= 1'b1;
      @(posedge SYS_CLK);
      chk({27'h0, offs}, 32'h0);
      RST <= 1'b0;
      @(posedge SYS_CLK);
      apb(1'b0, PMDB_ADDR_THREE, 32'h0, 4'h0, rd, err);
      chk(rd, 32'h0);
      $display("test second reset done");
      wrap_up();
   end
endmodule : testbench
